// ===== rtl/sequencer_pkg.sv
/*
  Shared constants and types for the operating-state controller of a safety power-supply device.
  Assumes a single 250 MHz core clock and a 32-bit classic Wishbone register port.
*/
`default_nettype none

package sequencer_pkg;

  // Operating states of the device controller.
  typedef enum logic [2:0] {ST_STANDBY, ST_RESET, ST_DIAG, ST_ACTIVE, ST_SAFE} op_state_t;

  // Register byte offsets and bus widths.
  localparam int unsigned ADR_W    = 8;
  localparam logic [7:0]  CTRL_OFS = 8'h00;
  localparam logic [7:0]  CFG_OFS  = 8'h04;
  localparam logic [7:0]  FLAG_OFS = 8'h08;
  localparam logic [7:0]  STAT_OFS = 8'h0c;

  // Write-only trigger bits in the control register.
  localparam int unsigned LST_START_BIT = 7;
  localparam int unsigned AST_START_BIT = 8;

  // Flag register bit positions.
  localparam int unsigned WATCHDOG_FAIL_FLAG_BIT    = 0;
  localparam int unsigned PIN_FAIL_BIT   = 1;
  localparam int unsigned WD_MIRROR_BIT  = 2;
  localparam int unsigned MCU_MIRROR_BIT = 3;
  localparam int unsigned WAKE_LATCH_BIT = 4;

  // Control register, low bits of the control word.
  typedef struct packed {
    logic diagnostic_hold;        // Bit 6.
    logic diagnostic_exit;        // Bit 5.
    logic auto_selftest_disable;  // Bit 4.
    logic watchdog_reset_enable;  // Bit 3.
    logic post_run_reset;         // Bit 2.
    logic key_switch_power_latch; // Bit 1.
    logic drive_enable_bit;       // Bit 0.
  } ctrl_t;

  // Configuration register, low 16 bits of the configuration word.
  typedef struct packed {
    logic       battery_overvoltage_mask;  // Bit 15.
    logic       core_regulator_unmask;     // Bit 14.
    logic       five_volt_overtemp_unmask; // Bit 13.
    logic       io_overtemp_unmask;        // Bit 12.
    logic       lockout_timeout_disable;   // Bit 11.
    logic [2:0] lockout_timeout_setting;   // Bits 10:8.
    logic [3:0] lock_threshold;            // Bits 7:4.
    logic [3:0] power_down_threshold;      // Bits 3:0.
  } cfg_t;

  // Monitor and pin levels that arrive from outside the clock domain.
  typedef struct packed {
    logic power_on_reset_n;
    logic battery_undervoltage;
    logic battery_overvoltage;
    logic clock_loss;
    logic logic_supply_undervoltage;
    logic logic_supply_overvoltage;
    logic monitor_supply_error;
    logic pump_rail_a_overvoltage;
    logic pump_rail_b_overvoltage;
    logic bandgap_error_a;
    logic bandgap_error_b;
    logic io_regulator_undervoltage;
    logic io_regulator_overtemp;
    logic five_volt_overtemp;
    logic core_regulator_undervoltage;
    logic regulator_overvoltage;
    logic key_switch_input;
    logic bus_wake_input;
    logic regulators_ramped;
  } supply_status_t;

  // Reset values and counter limits.
  localparam ctrl_t      CTRL_RST   = '0;
  localparam cfg_t       CFG_RST    = 16'h383f;
  localparam logic [2:0] WD_RELOAD  = 3'h5;
  localparam logic [2:0] WD_MAX     = 3'h7;
  localparam logic [2:0] WD_DRV_LIM = 3'h5;
  localparam logic [3:0] ERR_MAX    = 4'hf;

  // Timing in printed units and derived cycle counts at 250 MHz.
  localparam int unsigned TMR_W           = 28;
  localparam int unsigned CLK_KHZ         = 250000;
  localparam int unsigned DIAG_TIMEOUT_MS = 512;
  localparam int unsigned SAFE_UNIT_MS    = 22;
  localparam int unsigned SAFE_LOCK_MS    = 680;
  localparam int unsigned LOGIC_ST_MS     = 21;
  localparam int unsigned ANALOG_ST_US    = 300;
  localparam int unsigned RESET_EXT_US    = 1000;
  localparam logic [TMR_W-1:0] DIAG_TIMEOUT_CYC = TMR_W'(DIAG_TIMEOUT_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] SAFE_UNIT_CYC    = TMR_W'(SAFE_UNIT_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] SAFE_LOCK_CYC    = TMR_W'(SAFE_LOCK_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] LOGIC_ST_CYC     = TMR_W'(LOGIC_ST_MS * CLK_KHZ);
  localparam logic [TMR_W-1:0] ANALOG_ST_CYC    = TMR_W'(ANALOG_ST_US * CLK_KHZ / 1000);
  localparam logic [TMR_W-1:0] RESET_EXT_CYC    = TMR_W'(RESET_EXT_US * CLK_KHZ / 1000);

endpackage

`default_nettype wire

// ===== rtl/safety_device_state_controller.sv
/*
  Operating-state controller: sequences standby, reset, diagnostic, active and safe, drives the
  MCU reset and enable-drive outputs, and keeps the watchdog fail and device error counters.
  Assumes monitor levels arrive asynchronously, watchdog, error-monitor and NVM CRC strobes come
  from logic on clk_i, and software reaches the registers over classic Wishbone.

*/
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module safety_device_state_controller #(
  parameter logic [sequencer_pkg::TMR_W-1:0] DIAG_TIMEOUT_CYCLES = sequencer_pkg::DIAG_TIMEOUT_CYC,
  parameter logic [sequencer_pkg::TMR_W-1:0] SAFE_UNIT_CYCLES    = sequencer_pkg::SAFE_UNIT_CYC,
  parameter logic [sequencer_pkg::TMR_W-1:0] SAFE_LOCK_CYCLES    = sequencer_pkg::SAFE_LOCK_CYC,
  parameter logic [sequencer_pkg::TMR_W-1:0] LOGIC_ST_CYCLES     = sequencer_pkg::LOGIC_ST_CYC,
  parameter logic [sequencer_pkg::TMR_W-1:0] ANALOG_ST_CYCLES    = sequencer_pkg::ANALOG_ST_CYC,
  parameter logic [sequencer_pkg::TMR_W-1:0] RESET_EXT_CYCLES    = sequencer_pkg::RESET_EXT_CYC
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire sequencer_pkg::supply_status_t  supply_i,
  input  wire logic                           watchdog_bad_i,
  input  wire logic                           watchdog_good_i,
  input  wire logic                           esm_error_i,
  input  wire logic                           nvm_crc_done_i,
  input  wire logic                           nvm_crc_error_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [sequencer_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic [31:0]                         wb_dat_o,
  output logic                                wb_ack_o,
  output logic                                mcu_reset_out_o,
  output logic                                enable_drive_out_o,
  output logic                                regulators_on_o,
  output logic                                monitor_reset_o,
  output logic                                logic_selftest_o,
  output logic                                analog_selftest_o,
  output logic                                nvm_crc_run_o,
  output sequencer_pkg::op_state_t            op_state_o
);
  import sequencer_pkg::*;

  localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

  // Whole state of the controller, registered in one place.
  typedef struct packed {
    supply_status_t   sync1;
    supply_status_t   sync2;
    op_state_t        state;
    ctrl_t            ctrl;
    cfg_t             cfg;
    logic             watchdog_fail_flag;
    logic             pin_fail;
    logic             wd_mirror;
    logic             mcu_mirror;
    logic             wake_latched;
    logic [2:0]       wd_cnt;
    logic [3:0]       err_cnt;
    logic             from_standby;
    logic             key_low_seen;
    logic             crc_busy;
    logic             crc_fail;
    logic [TMR_W-1:0] diag_tmr;
    logic [TMR_W-1:0] safe_tmr;
    logic [TMR_W-1:0] rst_tmr;
    logic [TMR_W-1:0] lst_tmr;
    logic [TMR_W-1:0] ast_tmr;
    logic             ack;
    logic [31:0]      rdata;
    logic             mcu_reset;
    logic             enable_drive_out;
    logic             regs_on;
    logic             mon_rst;
    logic             lst_busy;
    logic             ast_busy;
  } seq_state_t;

  seq_state_t     state_ff;
  seq_state_t     nxt_state;
  supply_status_t mon;
  logic           bus_req;
  logic           bus_wr;
  logic           go_standby;
  logic           go_reset;
  logic           wd_reset_evt;
  logic           recrank;
  logic           wake_blocked;
  logic           diag_expired;
  logic           lock_below;
  logic [TMR_W-1:0] safe_target;
  logic [31:0]    read_word;

  // Merges the written bytes of a 16-bit register under the byte selects.
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] sel);
    logic [15:0] res;
    res = old_v;
    if (sel[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

  // True in states where the watchdog and error monitor are released from reset.
  function automatic logic monitors_run(input op_state_t st);
    return (st == ST_DIAG) || (st == ST_ACTIVE) || (st == ST_SAFE);
  endfunction

  // Next-state computation for bus, flags, counters, timers and the state machine.
  always_comb begin
    nxt_state = state_ff;
    mon = state_ff.sync2;
    nxt_state.sync1 = supply_i;
    nxt_state.sync2 = state_ff.sync1;
    bus_req = wb_cyc_i & wb_stb_i & ~state_ff.ack;
    bus_wr = bus_req & wb_we_i;
    wd_reset_evt = 1'b0;
    recrank = 1'b0;
    diag_expired = 1'b0;

    // Read data for the addressed register; unmapped addresses read zero.
    case (wb_adr_i)
      CTRL_OFS: read_word = {25'h0, state_ff.ctrl};
      CFG_OFS:  read_word = {16'h0, state_ff.cfg};
      FLAG_OFS: read_word = {27'h0, state_ff.wake_latched, state_ff.mcu_mirror, state_ff.wd_mirror,
                             state_ff.pin_fail, state_ff.watchdog_fail_flag};
      STAT_OFS: read_word = {16'h0, state_ff.crc_fail, state_ff.crc_busy, state_ff.ast_busy,
                             state_ff.lst_busy, state_ff.err_cnt, 1'b0, state_ff.wd_cnt, 1'b0,
                             3'(state_ff.state)};
      default:  read_word = 32'h0;
    endcase
    nxt_state.ack = bus_req;
    if (bus_req && !wb_we_i) begin
      nxt_state.rdata = read_word;
    end

    // Software writes; configuration is frozen while active.
    if (bus_wr && wb_adr_i == CTRL_OFS) begin
      nxt_state.ctrl = ctrl_t'(7'(merge16({9'h0, state_ff.ctrl}, wb_dat_i[15:0], wb_sel_i[1:0])));
    end
    if (bus_wr && wb_adr_i == CFG_OFS && state_ff.state != ST_ACTIVE) begin
      nxt_state.cfg = cfg_t'(merge16(state_ff.cfg, wb_dat_i[15:0], wb_sel_i[1:0]));
    end
    if (bus_wr && wb_adr_i == FLAG_OFS && wb_sel_i[0]) begin
      // Writing zero clears a fail flag together with its mirror.
      if (!wb_dat_i[WATCHDOG_FAIL_FLAG_BIT]) begin
        nxt_state.watchdog_fail_flag = 1'b0;
        nxt_state.wd_mirror = 1'b0;
      end
      if (!wb_dat_i[PIN_FAIL_BIT]) begin
        nxt_state.pin_fail = 1'b0;
        nxt_state.mcu_mirror = 1'b0;
      end
      if (!wb_dat_i[WAKE_LATCH_BIT]) begin
        nxt_state.wake_latched = 1'b0;
      end
    end

    // Self-test runs count down; a logic run clears the diagnostic hold bit.
    if (state_ff.lst_tmr != '0) begin
      nxt_state.lst_tmr = state_ff.lst_tmr - TMR_ONE;
    end
    if (state_ff.ast_tmr != '0) begin
      nxt_state.ast_tmr = state_ff.ast_tmr - TMR_ONE;
    end
    if (bus_wr && wb_adr_i == CTRL_OFS && (state_ff.state == ST_DIAG || state_ff.state == ST_ACTIVE)) begin
      if (wb_sel_i[0] && wb_dat_i[LST_START_BIT]) begin
        nxt_state.lst_tmr = LOGIC_ST_CYCLES;
        nxt_state.ctrl.diagnostic_hold = 1'b0;
      end
      if (wb_sel_i[1] && wb_dat_i[AST_START_BIT]) begin
        nxt_state.ast_tmr = ANALOG_ST_CYCLES;
      end
    end

    // Hardware sets come after software clears so a coincident event wins.
    if (mon.bus_wake_input) begin
      nxt_state.wake_latched = 1'b1;
    end
    if (monitors_run(state_ff.state)) begin
      if (watchdog_bad_i) begin
        if (state_ff.wd_cnt == WD_MAX) begin
          nxt_state.watchdog_fail_flag = 1'b1;
          nxt_state.wd_mirror = 1'b1;
          wd_reset_evt = state_ff.ctrl.watchdog_reset_enable;
        end else begin
          nxt_state.wd_cnt = state_ff.wd_cnt + 3'h1;
        end
      end else if (watchdog_good_i && state_ff.wd_cnt != 3'h0) begin
        nxt_state.wd_cnt = state_ff.wd_cnt - 3'h1;
      end
      if (esm_error_i && state_ff.state != ST_SAFE) begin
        nxt_state.pin_fail = 1'b1;
        nxt_state.mcu_mirror = 1'b1;
      end
    end

    // Recrank detection: a low then a valid high on the key switch.
    if (state_ff.state != ST_STANDBY && state_ff.ctrl.post_run_reset && state_ff.ctrl.key_switch_power_latch) begin
      if (!mon.key_switch_input) begin
        nxt_state.key_low_seen = 1'b1;
      end else if (state_ff.key_low_seen) begin
        recrank = 1'b1;
        nxt_state.key_low_seen = 1'b0;
      end
    end else begin
      nxt_state.key_low_seen = 1'b0;
    end

    // NVM CRC runs after each power-on reset; its verdict is held.
    if (!mon.power_on_reset_n) begin
      nxt_state.crc_busy = 1'b1;
      nxt_state.crc_fail = 1'b0;
    end else if (state_ff.crc_busy && nvm_crc_done_i) begin
      nxt_state.crc_busy = 1'b0;
      nxt_state.crc_fail = nvm_crc_error_i;
    end

    // Diagnostic time-out timer pauses while logic self-test runs.
    if (state_ff.state == ST_DIAG && state_ff.lst_tmr == '0) begin
      if (state_ff.diag_tmr == DIAG_TIMEOUT_CYCLES - TMR_ONE) begin
        diag_expired = 1'b1;
        nxt_state.diag_tmr = '0;
      end else begin
        nxt_state.diag_tmr = state_ff.diag_tmr + TMR_ONE;
      end
    end

    // Global transition conditions.
    go_standby = ~mon.power_on_reset_n | mon.battery_undervoltage | mon.clock_loss
               | mon.logic_supply_undervoltage | mon.logic_supply_overvoltage
               | mon.monitor_supply_error | mon.pump_rail_a_overvoltage | mon.pump_rail_b_overvoltage
               | mon.bandgap_error_a | mon.bandgap_error_b
               | (mon.io_regulator_overtemp & state_ff.cfg.io_overtemp_unmask)
               | (~mon.key_switch_input & ~state_ff.ctrl.key_switch_power_latch & ~state_ff.wake_latched)
               | state_ff.crc_fail
               | (state_ff.err_cnt >= state_ff.cfg.power_down_threshold);
    go_reset = mon.io_regulator_undervoltage
             | (mon.five_volt_overtemp & state_ff.cfg.five_volt_overtemp_unmask)
             | (mon.core_regulator_undervoltage & state_ff.cfg.core_regulator_unmask)
             | (mon.battery_overvoltage & ~state_ff.cfg.battery_overvoltage_mask)
             | wd_reset_evt | recrank;
    wake_blocked = mon.bandgap_error_a | mon.bandgap_error_b | mon.pump_rail_a_overvoltage
                 | mon.pump_rail_b_overvoltage | mon.monitor_supply_error
                 | state_ff.crc_fail | state_ff.crc_busy;
    lock_below = {1'b0, state_ff.err_cnt} < ({1'b0, state_ff.cfg.lock_threshold} + 5'h1);
    safe_target = TMR_W'({state_ff.cfg.lockout_timeout_setting, 1'b1}) * SAFE_UNIT_CYCLES;

    // State machine with standby first, then reset, then safe.
    case (state_ff.state)
      ST_STANDBY: begin
        if (!go_standby && !wake_blocked && (mon.key_switch_input || state_ff.wake_latched)) begin
          nxt_state.state = ST_RESET;
        end
      end
      ST_RESET: begin
        if (go_standby) begin
          nxt_state.state = ST_STANDBY;
        end else if (mon.regulators_ramped) begin
          if (state_ff.rst_tmr == RESET_EXT_CYCLES - TMR_ONE) begin
            nxt_state.state = ST_DIAG;
          end else begin
            nxt_state.rst_tmr = state_ff.rst_tmr + TMR_ONE;
          end
        end
      end
      ST_DIAG: begin
        if (go_standby) begin
          nxt_state.state = ST_STANDBY;
        end else if (go_reset) begin
          nxt_state.state = ST_RESET;
        end else if (state_ff.ctrl.diagnostic_hold) begin
          if (diag_expired) begin
            nxt_state.ctrl.diagnostic_exit = 1'b1;
          end
        end else if (state_ff.ctrl.diagnostic_exit) begin
          nxt_state.state = (state_ff.watchdog_fail_flag || state_ff.pin_fail) ? ST_SAFE : ST_ACTIVE;
        end else if (diag_expired) begin
          nxt_state.state = ST_SAFE;
          nxt_state.watchdog_fail_flag = 1'b1;
          nxt_state.wd_mirror = 1'b1;
          nxt_state.pin_fail = 1'b1;
          nxt_state.mcu_mirror = 1'b1;
        end
        // An error-monitor failure here only raises its flag.
      end
      ST_ACTIVE: begin
        if (go_standby) begin
          nxt_state.state = ST_STANDBY;
        end else if (go_reset) begin
          nxt_state.state = ST_RESET;
        end else if (esm_error_i) begin
          nxt_state.state = ST_SAFE;
        end
      end
      ST_SAFE: begin
        nxt_state.safe_tmr = state_ff.safe_tmr + TMR_ONE;
        if (go_standby) begin
          nxt_state.state = ST_STANDBY;
        end else if (go_reset) begin
          nxt_state.state = ST_RESET;
        end else if (lock_below && state_ff.safe_tmr >= safe_target - TMR_ONE) begin
          nxt_state.state = ST_RESET;
        end else if (!lock_below && !state_ff.cfg.lockout_timeout_disable
                     && state_ff.safe_tmr >= SAFE_LOCK_CYCLES - TMR_ONE) begin
          nxt_state.state = ST_RESET;
        end
      end
      default: begin
        nxt_state.state = ST_STANDBY;
      end
    endcase

    // Entry actions taken once on each change of state.
    if (nxt_state.state != state_ff.state) begin
      case (nxt_state.state)
        ST_RESET: begin
          nxt_state.rst_tmr = '0;
          nxt_state.from_standby = (state_ff.state == ST_STANDBY);
        end
        ST_DIAG: begin
          nxt_state.wd_cnt = WD_RELOAD;
          nxt_state.diag_tmr = '0;
          nxt_state.ctrl.diagnostic_exit = 1'b0;
          nxt_state.ctrl.diagnostic_hold = 1'b0;
          if (state_ff.from_standby || !state_ff.ctrl.auto_selftest_disable) begin
            nxt_state.lst_tmr = LOGIC_ST_CYCLES;
            nxt_state.ast_tmr = ANALOG_ST_CYCLES;
          end
        end
        ST_ACTIVE: begin
          nxt_state.wd_cnt = WD_RELOAD;
          nxt_state.ctrl.diagnostic_exit = 1'b0;
        end
        ST_SAFE: begin
          nxt_state.safe_tmr = '0;
          if (state_ff.err_cnt != ERR_MAX) begin
            nxt_state.err_cnt = state_ff.err_cnt + 4'h1;
          end
        end
        default: begin
          nxt_state.key_low_seen = 1'b0;
        end
      endcase
    end

    // Registered outputs derived from the next state.
    nxt_state.regs_on = (nxt_state.state != ST_STANDBY);
    nxt_state.mon_rst = ~monitors_run(nxt_state.state);
    nxt_state.mcu_reset = monitors_run(nxt_state.state);
    nxt_state.lst_busy = (nxt_state.lst_tmr != '0);
    nxt_state.ast_busy = (nxt_state.ast_tmr != '0);
    nxt_state.enable_drive_out = (nxt_state.state == ST_DIAG || nxt_state.state == ST_ACTIVE)
                    & nxt_state.ctrl.drive_enable_bit & (nxt_state.wd_cnt < WD_DRV_LIM)
                    & ~mon.regulator_overvoltage
                    & ~nxt_state.lst_busy & ~nxt_state.ast_busy;
  end

  // State register with synchronous reset to standby.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff          <= '0;
      state_ff.state    <= ST_STANDBY;
      state_ff.ctrl     <= CTRL_RST;
      state_ff.cfg      <= CFG_RST;
      state_ff.wd_cnt   <= WD_RELOAD;
      state_ff.crc_busy <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register.
  assign wb_dat_o           = state_ff.rdata;
  assign wb_ack_o           = state_ff.ack;
  assign mcu_reset_out_o    = state_ff.mcu_reset;
  assign enable_drive_out_o = state_ff.enable_drive_out;
  assign regulators_on_o    = state_ff.regs_on;
  assign monitor_reset_o    = state_ff.mon_rst;
  assign logic_selftest_o   = state_ff.lst_busy;
  assign analog_selftest_o  = state_ff.ast_busy;
  assign nvm_crc_run_o      = state_ff.crc_busy;
  assign op_state_o         = state_ff.state;

endmodule // safety_device_state_controller

`default_nettype wire

// ===== sim/sdsc_asserts.sv
/* Checker of state outputs and bus answer timing.
   Assumes binding to the controller top, handing on its reset-extension count. */
`timescale 1ns/10ps
`default_nettype none
module sdsc_asserts import sequencer_pkg::*; #(parameter logic [TMR_W-1:0] RESET_EXT_CYCLES = 28'h8) (
  input wire logic      clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, mcu_reset_out_o, enable_drive_out_o,
  input wire logic      regulators_on_o, monitor_reset_o, logic_selftest_o, analog_selftest_o, nvm_crc_run_o,
  input wire op_state_t op_state_o);
  logic [TMR_W-1:0] rst_cnt_ff;
  logic             up_ff;
  // Counts reset cycles and notes a pass through standby since the last diagnostic.
  always_ff @(posedge clk_i) begin
    rst_cnt_ff <= (op_state_o == ST_RESET) ? rst_cnt_ff + 1'b1 : '0;
    up_ff      <= rst_i || op_state_o == ST_STANDBY || (up_ff && op_state_o != ST_DIAG);
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence diag_entry;
    op_state_o == ST_RESET ##1 op_state_o == ST_DIAG;
  endsequence
  chk_standby_outs: assert property (
    op_state_o == ST_STANDBY |-> !mcu_reset_out_o && !enable_drive_out_o && !regulators_on_o) else $error("standby");
  chk_reset_outs: assert property (
    op_state_o == ST_RESET |-> !mcu_reset_out_o && !enable_drive_out_o && monitor_reset_o) else $error("reset");
  chk_diag_release: assert property (
    op_state_o inside {ST_DIAG, ST_ACTIVE} |-> mcu_reset_out_o && regulators_on_o) else $error("released");
  chk_safe_outs: assert property (
    op_state_o == ST_SAFE |-> mcu_reset_out_o && !enable_drive_out_o && regulators_on_o) else $error("safe");
  chk_selftest_drop: assert property (
    logic_selftest_o || analog_selftest_o |-> !enable_drive_out_o) else $error("drive in test");
  chk_power_up_test: assert property (
    diag_entry ##0 up_ff |-> logic_selftest_o || analog_selftest_o) else $error("no self-test");
  chk_reset_span: assert property (
    diag_entry |-> rst_cnt_ff >= RESET_EXT_CYCLES) else $error("reset too short");
  chk_crc_blocks_wake: assert property (
    op_state_o == ST_STANDBY && nvm_crc_run_o |=> op_state_o == ST_STANDBY) else $error("wake during crc");
  chk_ack_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack");
endmodule // sdsc_asserts
bind safety_device_state_controller sdsc_asserts #(.RESET_EXT_CYCLES(RESET_EXT_CYCLES)) chk_u (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mcu_reset_out_o, .enable_drive_out_o, .regulators_on_o, .monitor_reset_o,
  .logic_selftest_o, .analog_selftest_o, .nvm_crc_run_o, .op_state_o);
`default_nettype wire

// ===== sim/mcu_model.sv
/* Processor model that services the watchdog.
   Assumes it is released by the controller reset output. */
`timescale 1ns/10ps
`default_nettype none
module mcu_model (
  input  wire logic clk_i, rst_i, mcu_reset_i, serve_i,
  output logic      good_o);
  logic [3:0] tick_ff;
  // A held processor cannot service the watchdog, so pulses need the reset released.
  always_ff @(posedge clk_i) begin
    tick_ff <= rst_i ? 4'h0 : tick_ff + 4'h1;
    good_o  <= serve_i && mcu_reset_i && tick_ff == 4'hf;
  end
endmodule // mcu_model
`default_nettype wire

// ===== sim/tb.sv
/* Testbench walking the controller through its states.
   Assumes shortened counts and a read monitor fed by an expectation queue. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sequencer_pkg::*;
  logic           clk_i = 0, rst_i = 1, cyc = 0, we = 0, done = 0, serve = 0, ack, mcu_reset_out, enable_drive_out, good;
  logic           bad = 0, error_signal_monitor = 0, crc_err = 0;
  logic [7:0]     adr = '0;
  logic [3:0]     sel = '0;
  logic [15:0]    cfg_v;
  logic [31:0]    dat = '0, rdat;
  logic [35:0]    e, exp_q[$];
  supply_status_t sup = '0;
  op_state_t      st;
  int             miscompares = 0, total_checks = 0, seed = 32'hd1e37df0;
  always #2 clk_i = ~clk_i;
  safety_device_state_controller #(.DIAG_TIMEOUT_CYCLES(28'hc8), .SAFE_UNIT_CYCLES(28'h14),
    .SAFE_LOCK_CYCLES(28'h64), .LOGIC_ST_CYCLES(28'h1e), .ANALOG_ST_CYCLES(28'ha), .RESET_EXT_CYCLES(28'h8))
  dut_u (.clk_i, .rst_i, .supply_i(sup), .watchdog_bad_i(bad), .watchdog_good_i(good), .esm_error_i(error_signal_monitor),
    .nvm_crc_done_i(done), .nvm_crc_error_i(crc_err), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .mcu_reset_out_o(mcu_reset_out),
    .enable_drive_out_o(enable_drive_out), .regulators_on_o(), .monitor_reset_o(), .logic_selftest_o(),
    .analog_selftest_o(), .nvm_crc_run_o(), .op_state_o(st));
  mcu_model mcu_u (.clk_i, .rst_i, .mcu_reset_i(mcu_reset_out), .serve_i(serve), .good_o(good));
  // Compares each read answer and the two pins with the oldest note.
  always @(posedge clk_i) if (ack && !we) begin
    e = exp_q.pop_front();
    total_checks++;
    if ((({enable_drive_out, mcu_reset_out, rdat[15:0]} ^ e[17:0]) & e[35:18]) !== 18'h0) begin
      miscompares++;
      $display("ERROR read %h expected %h seen %h", adr, e[17:0], {enable_drive_out, mcu_reset_out, rdat[15:0]});
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; dat <= d;
    // Upper byte selects are random, since the registers only use the low two lanes.
    sel <= {2'($random(seed)), 2'h3};
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [17:0] m, input logic [17:0] v);
    exp_q.push_back({m, v});
    wb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input op_state_t s);
    repeat (3000) if (st !== s) @(posedge clk_i);
    if (st !== s) begin
      miscompares++;
      $display("ERROR state expected %0d seen %0d", s, st);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence: power-up, time-out to safe, active, then regulator and key faults.
  initial begin
    cfg_v = 16'h383f | (16'($random(seed)) & 16'h0700);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(STAT_OFS, 18'h30f07, 18'h0);
    rd(8'h10, 18'h0ffff, 18'h0);
    wb(1'b1, CFG_OFS, {16'h0, cfg_v});
    rd(CFG_OFS, 18'h0ffff, {2'b0, cfg_v});
    sup <= '{power_on_reset_n: 1'b1, key_switch_input: 1'b1, regulators_ramped: 1'b1, default: 1'b0};
    crc_err <= 1'b1;
    repeat (4) @(posedge clk_i);
    done <= 1'b1;
    crc_err <= 1'b0;
    @(posedge clk_i);
    done <= 1'b0;
    wt(ST_DIAG);
    rd(STAT_OFS, 18'h31f77, 18'h11052);
    wt(ST_SAFE);
    rd(STAT_OFS, 18'h30f07, 18'h10104);
    rd(FLAG_OFS, 18'h0000f, 18'h0000f);
    $display("test power_up done");
    wt(ST_DIAG);
    // One bad watchdog event and an emulated monitor failure while in diagnostic.
    bad <= 1'b1;
    error_signal_monitor <= 1'b1;
    @(posedge clk_i);
    bad <= 1'b0;
    error_signal_monitor <= 1'b0;
    rd(STAT_OFS, 18'h00077, 18'h00062);
    wb(1'b1, FLAG_OFS, 32'h0);
    rd(FLAG_OFS, 18'h0000f, 18'h0);
    wb(1'b1, CTRL_OFS, 32'h21);
    wt(ST_ACTIVE);
    rd(STAT_OFS, 18'h30f77, 18'h10153);
    serve <= 1'b1;
    repeat (200) @(posedge clk_i);
    rd(STAT_OFS, 18'h20000, 18'h20000);
    $display("test active done");
    sup.io_regulator_undervoltage <= 1'b1;
    wt(ST_RESET);
    rd(STAT_OFS, 18'h30007, 18'h00001);
    sup.io_regulator_undervoltage <= 1'b0;
    sup.key_switch_input <= 1'b0;
    wt(ST_STANDBY);
    rd(STAT_OFS, 18'h30007, 18'h0);
    $display("test faults done");
    @(posedge clk_i);
    tally_and_finish();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
